/* File: serial_loaded_quad_pll_clock_config_test.sv */
module serial_loaded_quad_pll_clock_config_test;
	import sqp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic                clk_sys = 1'b0, rst = 1'b1, start = 1'b0, outEnable = 1'b0, refIn = 1'b0;
	logic                busy, stable, prevSclk = 1'b0;
	logic [CFG_BITS-1:0] cfgWord = '0, seenBits = '0;
	logic [NUM_OUT-1:0]  clkOut, clkOutEn;
	int                  fails = 0, cmp_count = 0, cycles = 0, seed = 32'h0c768ba7, waited = 0;
	localparam int       LOCK_T = 20;
	localparam int       WAKE_T = 5;
	sqp_if link ();
	sqp_host sqp_host_inst (.clk_sys(clk_sys), .rst(rst), .start(start), .cfgWord(cfgWord),
		.outEnable(outEnable), .busy(busy), .link(link.host));
	sqp_device #(.LOCK_CYCLES(LOCK_T), .WAKE_CYCLES(WAKE_T)) sqp_device_inst (.clk_sys(clk_sys),
		.rst(rst), .link(link.device), .reference_clock_input(refIn), .clkOut(clkOut),
		.clkOutEn(clkOutEn), .outStable(stable));
	sqp_assertions sqp_assertions_inst (.clk_sys(clk_sys), .rst(rst),
		.serialData(link.serialData), .shiftClk(link.shiftClk), .loadStrobe(link.loadStrobe),
		.power_down_tristate_n(link.power_down_tristate_n));
	always #20 clk_sys = ~clk_sys;
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			fails++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic waitFor(ref logic s, input logic lvl, input int lim);
		int n;
		n = 0;
		while (s !== lvl && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		waited = n;
	endtask
	task automatic countToggles(input int o, input int n, output int c);
		logic last;
		c = 0;
		last = clkOut[o];
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			if (clkOut[o] !== last) c++;
			last = clkOut[o];
		end
	endtask
	// Output level changes in n cycles: n * M / (N * divider), divider clamped
	function automatic int expToggles(input logic [CFG_BITS-1:0] v, input int o, input int n);
		int p, m, d, od;
		p  = v[OUT_SEL_LSB+o*2 +: 2];
		m  = v[PLL_MUL_LSB+p*MUL_W +: MUL_W] + 1;
		d  = v[PLL_DIV_LSB+p*DIV_W +: DIV_W] + 1;
		od = v[OUT_DIV_LSB+o*ODIV_W +: ODIV_W];
		od = (od < int'(ODIV_MIN)) ? int'(ODIV_MIN) : (od > int'(ODIV_MAX)) ? int'(ODIV_MAX) : od;
		return n * m / (d * od);
	endfunction
	// Wire-side shadow of the shift register, rebuilt from the pins alone
	always @(posedge clk_sys) begin
		prevSclk <= link.shiftClk;
		if (link.shiftClk && !prevSclk) seenBits <= {seenBits[CFG_BITS-2:0], link.serialData};
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			$display("BAD %0t timeout", $time);
			conclude();
		end
	end
	initial begin
		logic [CFG_BITS-1:0] w;
		int                  tog;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			refIn <= i[0];
			repeat (3) @(posedge clk_sys);
			#1;
			check(clkOut === {NUM_OUT{refIn}}, "default not reference");
			check(clkOutEn === '0, "outputs driven in power-down");
		end
		$display("test defaults done");
		outEnable <= 1'b1;
		for (int t = 0; t < 4; t++) begin
			w = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
			if (t == 1) w = '1;
			// Corner word with whole-cycle rates: M=1, N=2, dividers 4 and 8
			if (t == 2) begin
				for (int k = 0; k < NUM_PLL; k++) begin
					w[PLL_MUL_LSB+k*MUL_W +: MUL_W] = 11'h000;
					w[PLL_DIV_LSB+k*DIV_W +: DIV_W] = 10'h001;
				end
				for (int k = 0; k < NUM_OUT; k++) begin
					w[OUT_DIV_LSB+k*ODIV_W +: ODIV_W] = 5'h04;
					w[OUT_SEL_LSB+k*2 +: 2] = 2'h0;
				end
				w[OUT_DIV_LSB+(NUM_OUT-1)*ODIV_W +: ODIV_W] = 5'h08;
			end
			w[PROG_BIT] = 1'b1;
			@(posedge clk_sys);
			cfgWord <= w;
			start <= 1'b1;
			@(posedge clk_sys);
			start <= 1'b0;
			// A second start mid-shift with another word must be ignored
			@(posedge clk_sys);
			cfgWord <= ~w;
			start <= 1'b1;
			@(posedge clk_sys);
			start <= 1'b0;
			#1;
			waitFor(busy, 1'b0, 400);
			check(seenBits === w, "word on wire");
			check(link.loadStrobe === 1'b1, "strobe not high");
			check(stable === 1'b0, "stable before lock time");
			waitFor(stable, 1'b1, 40);
			check(stable === 1'b1, "not stable after load");
			check(waited == LOCK_T, "lock time wrong");
			check(clkOutEn === '1, "outputs not driven");
			if (t == 2) begin
				countToggles(0, 64, tog);
				check(tog == expToggles(w, 0, 64), "output 1 rate wrong");
				countToggles(NUM_OUT - 1, 64, tog);
				check(tog == expToggles(w, NUM_OUT - 1, 64), "output 9 rate wrong");
			end
			@(posedge clk_sys);
			outEnable <= 1'b0;
			repeat (3) @(posedge clk_sys);
			#1;
			check(clkOutEn === '0, "outputs not off");
			@(posedge clk_sys);
			outEnable <= 1'b1;
			repeat (2) @(posedge clk_sys);
			#1;
			check(stable === 1'b0, "stable before wake time");
			waitFor(stable, 1'b1, 40);
			check(stable === 1'b1, "not stable after wake");
			check(waited == WAKE_T - 2, "wake time wrong");
			$display("test program %0d done", t);
		end
		conclude();
	end
endmodule // serial_loaded_quad_pll_clock_config_test

/* File: sqp_assertions.sv */
module sqp_assertions (
	input wire logic clk_sys,              // System clock
	input wire logic rst,                  // Async reset
	input wire logic serialData,           // Data line
	input wire logic shiftClk,             // Shift clock
	input wire logic loadStrobe,           // Load strobe
	input wire logic power_down_tristate_n // Outputs-on level
);
	logic [7:0] bitCnt_ff;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence bitSlot;
		!shiftClk ##1 shiftClk;
	endsequence
	// Counts shift pulses since the strobe fell, so a short or long word is caught at load
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) bitCnt_ff <= 8'h00;
		else if ($fell(loadStrobe)) bitCnt_ff <= 8'h00;
		else if ($rose(shiftClk)) bitCnt_ff <= bitCnt_ff + 8'h01;
	end
	chk_strobe_low_shift: assert property (shiftClk |-> !loadStrobe)
		else $error("shift pulse while strobe high");
	chk_clk_one_cycle: assert property ($rose(shiftClk) |=> !shiftClk)
		else $error("shift clock high too long");
	chk_data_hold: assert property (shiftClk |-> $stable(serialData))
		else $error("data moved while shift clock high");
	chk_first_slot: assert property ($fell(loadStrobe) |-> bitSlot)
		else $error("first bit slot late");
	chk_bit_pace: assert property ($rose(shiftClk) && bitCnt_ff < 8'h9f |=> bitSlot)
		else $error("bit pace broken");
	chk_bit_total: assert property ($rose(loadStrobe) |-> bitCnt_ff == 8'ha0)
		else $error("word length not 160");
	chk_load_after: assert property ($rose(shiftClk) && bitCnt_ff == 8'h9f
		|-> ##[1:3] $rose(loadStrobe))
		else $error("strobe late after last bit");
	chk_pdn_loaded: assert property ($rose(power_down_tristate_n) |-> loadStrobe)
		else $error("outputs released before load");
endmodule // sqp_assertions

/* File: sqp_device.sv */
module sqp_device
	import sqp_pkg::*;
#(
	parameter int LOCK_CYCLES = LOCK_CYC,
	parameter int WAKE_CYCLES = WAKE_CYC
) (
	input  wire logic       clk_sys,               // System clock
	input  wire logic       rst,                   // Async reset, active high
	sqp_if.device           link,                  // Three-wire programming pins
	input  wire logic       reference_clock_input, // Reference clock level
	output logic [NUM_OUT-1:0] clkOut,             // Clock output levels
	output logic [NUM_OUT-1:0] clkOutEn,           // Output drive enables
	output logic            outStable              // Outputs locked and stable
);
	logic [CFG_BITS-1:0] shift_ff;
	logic [CFG_BITS-1:0] latch_ff;
	logic                sclkPrev_ff;
	logic                stbPrev_ff;
	logic                programmed_ff;
	logic [CNT_W-1:0]    settle_ff;
	logic [NUM_PLL-1:0]  vco;
	logic [CFG_BITS-1:0] nxt_shift;
	logic                sclkRise;
	logic                pdn;

	assign sclkRise  = link.shiftClk & ~sclkPrev_ff;
	assign pdn       = ~link.power_down_tristate_n;
	assign nxt_shift = {shift_ff[CFG_BITS-2:0], link.serialData};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sclkPrev_ff <= 1'b0;
			// Strobe idles high, so no false load edge right after reset
			stbPrev_ff  <= 1'b1;
		end else begin
			sclkPrev_ff <= link.shiftClk;
			stbPrev_ff  <= link.loadStrobe;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shift_ff <= '0;
		end else if (sclkRise) begin
			shift_ff <= nxt_shift;
		end
	end

	// Transparent latch modelled synchronously: follows the shifter while strobe is high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			latch_ff      <= '0;
			programmed_ff <= 1'b0;
		end else if (link.loadStrobe && (!stbPrev_ff || sclkRise)) begin
			// A shift pulse on the strobe edge itself must reach the latch too
			latch_ff      <= sclkRise ? nxt_shift : shift_ff;
			programmed_ff <= sclkRise ? nxt_shift[PROG_BIT] : shift_ff[PROG_BIT];
		end
	end

	// Settle counter restarts on every load; while powered down it is raised to at least the wake time
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			settle_ff <= '0;
		end else if (link.loadStrobe && !stbPrev_ff) begin
			settle_ff <= CNT_W'(LOCK_CYCLES);
		end else if (pdn) begin
			// Held at no less than the wake time while powered down; a pending lock time outlasts the wake time
			if (settle_ff < CNT_W'(WAKE_CYCLES)) begin
				settle_ff <= CNT_W'(WAKE_CYCLES);
			end
		end else if (settle_ff != '0) begin
			settle_ff <= settle_ff - 1'b1;
		end
	end
	assign outStable = ~pdn && (settle_ff == '0);

	// Fractional M/N synthesis: accumulator adds M, wraps at N, toggles the VCO
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PLL; gp++) begin : g_pll
			logic [MUL_W-1:0] mulSet;
			logic [DIV_W-1:0] divSet;
			logic [11:0]      mulVal;
			logic [10:0]      divVal;
			logic [DIV_W+MUL_W:0] sum;
			logic [DIV_W+MUL_W:0] acc_ff;
			logic [MUL_W-1:0]     phase_ff;
			assign mulSet = latch_ff[PLL_MUL_LSB+gp*MUL_W +: MUL_W];
			assign divSet = latch_ff[PLL_DIV_LSB+gp*DIV_W +: DIV_W];
			assign mulVal = {1'b0, mulSet} + 12'h001;
			assign divVal = {1'b0, divSet} + 11'h001;
			assign sum    = acc_ff + (DIV_W+MUL_W+1)'(mulVal);
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					acc_ff   <= '0;
					phase_ff <= '0;
				end else if (!pdn) begin
					if (acc_ff >= (DIV_W+MUL_W+1)'(divVal)) begin
						// Remainder left by a larger divider or by M above N; restart
						acc_ff   <= '0;
						phase_ff <= phase_ff + 1'b1;
					end else if (sum >= (DIV_W+MUL_W+1)'(divVal)) begin
						acc_ff   <= sum - (DIV_W+MUL_W+1)'(divVal);
						phase_ff <= phase_ff + 1'b1;
					end else begin
						acc_ff <= sum;
					end
				end
			end
			assign vco[gp] = phase_ff[0];
		end
	endgenerate

	// Output dividers; counter kept across reloads so duty stays near half
	genvar go;
	generate
		for (go = 0; go < NUM_OUT; go++) begin : g_out
			logic [ODIV_W-1:0] odRaw;
			logic [ODIV_W-1:0] odVal;
			logic [1:0]        sel;
			logic              src;
			logic              srcPrev_ff;
			logic [ODIV_W-1:0] ocnt_ff;
			logic              oclk_ff;
			assign odRaw = latch_ff[OUT_DIV_LSB+go*ODIV_W +: ODIV_W];
			assign odVal = (odRaw < ODIV_MIN) ? ODIV_MIN :
				(odRaw > ODIV_MAX) ? ODIV_MAX : odRaw;
			assign sel   = latch_ff[OUT_SEL_LSB+go*2 +: 2];
			assign src   = vco[sel];
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					srcPrev_ff <= 1'b0;
					ocnt_ff    <= '0;
					oclk_ff    <= 1'b0;
				end else begin
					srcPrev_ff <= src;
					if (src && !srcPrev_ff) begin
						if (ocnt_ff >= (odVal >> 1) - 1'b1) begin
							ocnt_ff <= '0;
							oclk_ff <= ~oclk_ff;
						end else begin
							ocnt_ff <= ocnt_ff + 1'b1;
						end
					end
				end
			end
			// Reference buffered straight through until programmed
			assign clkOut[go]   = programmed_ff ? oclk_ff : reference_clock_input;
			assign clkOutEn[go] = ~pdn;
		end
	endgenerate
endmodule : sqp_device

/* File: sqp_host.sv */
module sqp_host
	import sqp_pkg::*;
(
	input  wire logic                clk_sys,   // System clock
	input  wire logic                rst,       // Async reset, active high
	input  wire logic                start,     // Pulse: program cfgWord
	input  wire logic [CFG_BITS-1:0] cfgWord,   // Configuration word
	input  wire logic                outEnable, // Request outputs running
	output logic                     busy,      // Programming in progress
	sqp_if.host                      link       // Three-wire programming pins
);
	typedef enum logic [3:0] {
		IDLE  = 4'h1,
		LOW   = 4'h2,
		HIGH  = 4'h4,
		STRB  = 4'h8
	} sqp_state_t;

	sqp_state_t          state_ff;
	logic [CFG_BITS-1:0] word_ff;
	logic [7:0]          bitCnt_ff;
	logic                loaded_ff;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff  <= IDLE;
			word_ff   <= '0;
			bitCnt_ff <= '0;
			loaded_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				IDLE: begin
					if (start) begin
						word_ff   <= cfgWord;
						bitCnt_ff <= '0;
						loaded_ff <= 1'b0;
						state_ff  <= LOW;
					end
				end
				LOW: state_ff <= HIGH;
				HIGH: begin
					word_ff   <= {word_ff[CFG_BITS-2:0], 1'b0};
					bitCnt_ff <= bitCnt_ff + 8'h01;
					state_ff  <= (bitCnt_ff == 8'(CFG_BITS - 1)) ? STRB : LOW;
				end
				STRB: begin
					loaded_ff <= 1'b1;
					state_ff  <= IDLE;
				end
			endcase
		end
	end

	assign busy                       = (state_ff != IDLE);
	assign link.serialData            = word_ff[CFG_BITS-1];
	assign link.shiftClk              = (state_ff == HIGH);
	// Strobe idles high as a pull-up would; held low only while shifting
	assign link.loadStrobe            = ~(state_ff == LOW || state_ff == HIGH);
	assign link.power_down_tristate_n = loaded_ff & outEnable;
endmodule : sqp_host

/* File: sqp_if.sv */
interface sqp_if;
	logic serialData;
	logic shiftClk;
	logic loadStrobe;
	logic power_down_tristate_n;
	modport device (input serialData, input shiftClk, input loadStrobe,
		input power_down_tristate_n);
	modport host (output serialData, output shiftClk, output loadStrobe,
		output power_down_tristate_n);
endinterface : sqp_if

/* File: sqp_pkg.sv */
package sqp_pkg;
	localparam int          CFG_BITS      = 160;
	localparam int          NUM_OUT       = 9;
	localparam int          NUM_PLL       = 4;
	localparam int          MUL_W         = 11;
	localparam int          DIV_W         = 10;
	localparam int          ODIV_W        = 5;
	localparam logic [11:0] MUL_MAX       = 12'h800;
	localparam logic [10:0] NDIV_MAX      = 11'h400;
	localparam logic [4:0]  ODIV_MIN      = 5'h02;
	localparam logic [4:0]  ODIV_MAX      = 5'h14;
	// Field layout of the configuration word, one entry per PLL then per output
	localparam int          PLL_MUL_LSB   = 0;
	localparam int          PLL_DIV_LSB   = 44;
	localparam int          OUT_DIV_LSB   = 84;
	localparam int          OUT_SEL_LSB   = 129;
	localparam int          PROG_BIT      = 159;
	localparam int          CLK_HZ        = 25000000;
	localparam int          LOCK_MS       = 10;
	localparam int          WAKE_MS       = 2;
	localparam int          LOCK_CYC      = CLK_HZ / 1000 * LOCK_MS;
	localparam int          WAKE_CYC      = CLK_HZ / 1000 * WAKE_MS;
	localparam int          CNT_W         = 24;
	localparam int          SHIFT_DIV     = 2;
endpackage : sqp_pkg
